/* src/ccl_pkg.sv */
// constants and register map of the comparator control logic
package ccl_pkg;

    // ********************************************************
    // bus geometry
    // ********************************************************
    localparam int CCL_ADDR_W = 8;
    localparam int CCL_DATA_W = 32;
    localparam int CCL_BE_W = 4;
    localparam int CCL_REG_W = 8;
    localparam int CCL_IDX_W = 6;
    localparam int CCL_LVL_W = 8;
    localparam int CCL_ADC_PINS = 4;
    localparam int CCL_AIN_PINS = 2;
    localparam int CCL_IRQ_W = 2;

    // ********************************************************
    // register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [CCL_IDX_W-1:0] CCL_IDX_ADCSB = 6'h03;
    localparam logic [CCL_IDX_W-1:0] CCL_IDX_CMPCS = 6'h08;
    localparam logic [CCL_IDX_W-1:0] CCL_IDX_DIDIS = 6'h14;
    localparam logic [CCL_IDX_W-1:0] CCL_IDX_CONV = 6'h04;
    localparam logic [CCL_IDX_W-1:0] CCL_IDX_ISTAT = 6'h18;
    localparam logic [CCL_IDX_W-1:0] CCL_IDX_ICLR = 6'h19;
    localparam logic [CCL_IDX_W-1:0] CCL_IDX_IEN = 6'h1a;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int CCL_B_BIPOLAR = 7;
    localparam int CCL_B_MUXEN = 6;
    localparam int CCL_B_POLREV = 5;
    localparam int CCL_B_CMPOFF = 7;
    localparam int CCL_B_BGSEL = 6;
    localparam int CCL_B_RESULT = 5;
    localparam int CCL_B_FLAG = 4;
    localparam int CCL_B_IRQEN = 3;
    localparam int CCL_B_CONVEN = 7;
    localparam int CCL_IST_EVENT = 0;
    localparam int CCL_IST_TOGGLE = 1;

    // ********************************************************
    // writable masks and reset values
    // ********************************************************
    localparam logic [7:0] CCL_ADCSB_WMASK = 8'he7;
    localparam logic [7:0] CCL_DIDIS_WMASK = 8'h3f;
    localparam logic [7:0] CCL_ADCSB_RST = 8'h00;
    localparam logic [7:0] CCL_DIDIS_RST = 8'h00;
    localparam logic [7:0] CCL_CONV_RST = 8'h00;
    localparam logic [1:0] CCL_MODE_RST = 2'h0;

    // ********************************************************
    // event modes and the fixed bandgap level
    // ********************************************************
    localparam logic [1:0] CCL_MODE_TOGGLE = 2'h0;
    localparam logic [1:0] CCL_MODE_RSVD = 2'h1;
    localparam logic [1:0] CCL_MODE_FALL = 2'h2;
    localparam logic [1:0] CCL_MODE_RISE = 2'h3;
    localparam logic [CCL_LVL_W-1:0] CCL_BANDGAP_LVL = 8'h38;

endpackage : ccl_pkg

/* src/ccl_sync_edge.sv */
// two-stage synchroniser and edge detector for the comparator result
`timescale 1ns/1ps
module ccl_sync_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw result and synchronised view
    input wire logic raw_in,
    output logic sync_q,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic prev_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync_q;
        end
    end

    // one event per transition of the synchronised bit
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    sync_lag_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst, 2) |-> sync_q == $past(raw_in, 2))
        else $error("synchronised result does not lag raw by two");

    // a short pulse on the raw result legally gives two events in a row
    one_edge_a: assert property (@(posedge clk) disable iff (rst)
        (rise || fall) == (sync_q != $past(sync_q)))
        else $error("event flags disagree with the synchronised change");

endmodule : ccl_sync_edge

/* src/ccl_top.sv */
// comparator control logic with its avalon register slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps

module ccl_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [ccl_pkg::CCL_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ccl_pkg::CCL_DATA_W-1:0] avs_writedata,
    input wire logic [ccl_pkg::CCL_BE_W-1:0] avs_byteenable,
    output logic [ccl_pkg::CCL_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // analog levels seen by the comparator
    input wire logic [ccl_pkg::CCL_LVL_W-1:0] positive_pin,
    input wire logic [ccl_pkg::CCL_LVL_W-1:0] negative_pin,
    input wire logic [ccl_pkg::CCL_ADC_PINS*ccl_pkg::CCL_LVL_W-1:0] adc_pin,
    // digital side of the two comparator pins
    input wire logic [ccl_pkg::CCL_AIN_PINS-1:0] pin_digital_in,
    output logic [ccl_pkg::CCL_AIN_PINS-1:0] pin_read,
    output logic [ccl_pkg::CCL_AIN_PINS-1:0] pin_buffer_off,
    // processor side
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    output logic comparator_power_off,
    output logic comparator_irq
);
    import ccl_pkg::*;

    // ********************************************************
    // registers
    // ********************************************************
    logic [7:0] adcsb_q;
    logic [7:0] didis_q;
    logic [7:0] conv_q;
    logic cmp_off_q;
    logic bg_sel_q;
    logic flag_q;
    logic irq_en_q;
    logic [1:0] mode_q;
    logic [CCL_IRQ_W-1:0] istat_q;
    logic [CCL_IRQ_W-1:0] ien_q;
    logic wait_q;
    logic [CCL_DATA_W-1:0] rdata_q;
    logic [CCL_DATA_W-1:0] rdata_d;
    logic [CCL_AIN_PINS-1:0] pin_read_q;
    logic [CCL_AIN_PINS-1:0] pin_off_q;
    logic power_off_q;
    logic irq_q;

    // ********************************************************
    // bus decode
    // ********************************************************
    logic [CCL_IDX_W-1:0] idx;
    logic wr_acc;
    logic rd_take;
    logic lane0;
    logic [7:0] wbyte;

    assign idx = avs_address[CCL_ADDR_W-1:2];
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    // a write lands on the edge where waitrequest is seen low
    assign wr_acc = avs_write & ~wait_q & lane0;
    assign rd_take = avs_read & wait_q;

    logic wr_adcsb;
    logic wr_cmpcs;
    logic wr_didis;
    logic wr_conv;
    logic wr_iclr;
    logic wr_ien;

    assign wr_adcsb = wr_acc && idx == CCL_IDX_ADCSB;
    assign wr_cmpcs = wr_acc && idx == CCL_IDX_CMPCS;
    assign wr_didis = wr_acc && idx == CCL_IDX_DIDIS;
    assign wr_conv = wr_acc && idx == CCL_IDX_CONV;
    assign wr_iclr = wr_acc && idx == CCL_IDX_ICLR;
    assign wr_ien = wr_acc && idx == CCL_IDX_IEN;

    // ********************************************************
    // input selection and the comparator model
    // ********************************************************
    logic muxed_path;
    logic [CCL_LVL_W-1:0] pos_lvl;
    logic [CCL_LVL_W-1:0] neg_lvl;
    logic raw_result;
    logic [1:0] chan_sel;
    logic conv_en;

    assign chan_sel = conv_q[1:0];
    assign conv_en = conv_q[CCL_B_CONVEN];
    // the converter owns its multiplexer while it is switched on
    assign muxed_path = adcsb_q[CCL_B_MUXEN] & ~conv_en;

    always_comb begin
        if (muxed_path) begin
            neg_lvl = adc_pin[chan_sel*CCL_LVL_W +: CCL_LVL_W];
        end else begin
            neg_lvl = negative_pin;
        end
    end

    assign pos_lvl = bg_sel_q ? CCL_BANDGAP_LVL : positive_pin;
    // a powered-down comparator holds its output low
    assign raw_result = ~cmp_off_q & (pos_lvl > neg_lvl);

    logic sync_res;
    logic ev_rise;
    logic ev_fall;

    ccl_sync_edge u_sync (
        .clk(clk),
        .rst(rst),
        .raw_in(raw_result),
        .sync_q(sync_res),
        .rise(ev_rise),
        .fall(ev_fall)
    );

    logic ev_match;
    always_comb begin
        unique case (mode_q)
            CCL_MODE_TOGGLE: ev_match = ev_rise | ev_fall;
            CCL_MODE_FALL: ev_match = ev_fall;
            CCL_MODE_RISE: ev_match = ev_rise;
            // reserved code raises nothing
            CCL_MODE_RSVD: ev_match = 1'b0;
        endcase
    end

    // ********************************************************
    // control registers
    // ********************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            adcsb_q <= CCL_ADCSB_RST;
        end else if (wr_adcsb) begin
            adcsb_q <= wbyte & CCL_ADCSB_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            didis_q <= CCL_DIDIS_RST;
        end else if (wr_didis) begin
            didis_q <= wbyte & CCL_DIDIS_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_q <= CCL_CONV_RST;
        end else if (wr_conv) begin
            conv_q <= wbyte;
        end
    end

    // bit 2 has no storage at all
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_off_q <= 1'b0;
            bg_sel_q <= 1'b0;
            irq_en_q <= 1'b0;
            mode_q <= CCL_MODE_RST;
        end else if (wr_cmpcs) begin
            cmp_off_q <= wbyte[CCL_B_CMPOFF];
            bg_sel_q <= wbyte[CCL_B_BGSEL];
            irq_en_q <= wbyte[CCL_B_IRQEN];
            mode_q <= wbyte[1:0];
        end
    end

    // set wins over both the vector clear and the software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ev_match) begin
            flag_q <= 1'b1;
        end else if (irq_vector_ack) begin
            flag_q <= 1'b0;
        end else if (wr_cmpcs && wbyte[CCL_B_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    // ********************************************************
    // sticky interrupt status
    // ********************************************************
    logic [CCL_IRQ_W-1:0] ist_set;
    assign ist_set[CCL_IST_EVENT] = ev_match;
    assign ist_set[CCL_IST_TOGGLE] = ev_rise | ev_fall;

    genvar gi;
    generate
        for (gi = 0; gi < CCL_IRQ_W; gi++) begin : g_ist
            always_ff @(posedge clk) begin
                if (rst) begin
                    istat_q[gi] <= 1'b0;
                end else if (ist_set[gi]) begin
                    istat_q[gi] <= 1'b1;
                end else if (wr_iclr && wbyte[gi]) begin
                    istat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            ien_q <= '0;
        end else if (wr_ien) begin
            ien_q <= wbyte[CCL_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (flag_q & irq_en_q & global_irq_enable)
                | (|(istat_q & ien_q));
        end
    end

    // ********************************************************
    // pins and power
    // ********************************************************
    generate
        for (gi = 0; gi < CCL_AIN_PINS; gi++) begin : g_pin
            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_off_q[gi] <= 1'b0;
                    pin_read_q[gi] <= 1'b0;
                end else begin
                    pin_off_q[gi] <= didis_q[gi];
                    pin_read_q[gi] <= pin_digital_in[gi] & ~didis_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            power_off_q <= 1'b0;
        end else begin
            power_off_q <= cmp_off_q;
        end
    end

    // ********************************************************
    // read path and wait state
    // ********************************************************
    always_comb begin
        rdata_d = '0;
        unique case (idx)
            CCL_IDX_ADCSB: rdata_d[7:0] = adcsb_q;
            CCL_IDX_CMPCS: rdata_d[7:0] = {cmp_off_q, bg_sel_q, sync_res,
                flag_q, irq_en_q, 1'b0, mode_q};
            CCL_IDX_DIDIS: rdata_d[7:0] = didis_q;
            CCL_IDX_CONV: rdata_d[7:0] = conv_q;
            CCL_IDX_ISTAT: rdata_d[CCL_IRQ_W-1:0] = istat_q;
            CCL_IDX_IEN: rdata_d[CCL_IRQ_W-1:0] = ien_q;
            default: rdata_d = '0;
        endcase
    end

    // exactly one wait state; waitrequest drops for one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~((avs_read | avs_write) & wait_q);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (rd_take) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pin_read = pin_read_q;
    assign pin_buffer_off = pin_off_q;
    assign comparator_power_off = power_off_q;
    assign comparator_irq = irq_q;

    // ********************************************************
    // checks
    // ********************************************************
    sequence cmpcs_write_s;
        wr_cmpcs;
    endsequence

    sequence matched_event_s;
        ev_match ##1 flag_q;
    endsequence

    raw_compare_a: assert property (@(posedge clk) disable iff (rst)
        !cmp_off_q |-> raw_result == (pos_lvl > neg_lvl))
        else $error("raw result disagrees with the inputs");

    neg_pin_a: assert property (@(posedge clk) disable iff (rst)
        (!adcsb_q[CCL_B_MUXEN] || conv_en) |-> neg_lvl == negative_pin)
        else $error("negative pin not selected");

    neg_mux_a: assert property (@(posedge clk) disable iff (rst)
        (adcsb_q[CCL_B_MUXEN] && !conv_en && chan_sel == 2'h2)
        |-> neg_lvl == adc_pin[23:16])
        else $error("wrong converter pin on negative input");

    pos_bandgap_a: assert property (@(posedge clk) disable iff (rst)
        pos_lvl == (bg_sel_q ? CCL_BANDGAP_LVL : positive_pin))
        else $error("positive input selection wrong");

    power_off_a: assert property (@(posedge clk) disable iff (rst)
        cmpcs_write_s |=> ##1 comparator_power_off == $past(wbyte[7], 2))
        else $error("power off output does not follow disable bit");

    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        ev_match |-> matched_event_s)
        else $error("matching event did not set the flag");

    vector_clear_a: assert property (@(posedge clk) disable iff (rst)
        (irq_vector_ack && !ev_match) |=> !flag_q)
        else $error("vector entry did not clear the flag");

    w1c_flag_a: assert property (@(posedge clk) disable iff (rst)
        (cmpcs_write_s and (!wbyte[CCL_B_FLAG] && !irq_vector_ack))
        |=> flag_q == $past(flag_q) || $past(ev_match))
        else $error("writing zero changed the flag");

    irq_request_a: assert property (@(posedge clk) disable iff (rst)
        (ien_q == '0) |=> comparator_irq
            == $past(flag_q & irq_en_q & global_irq_enable))
        else $error("interrupt request does not match its terms");

    reserved_bit_a: assert property (@(posedge clk) disable iff (rst)
        (rd_take && idx == CCL_IDX_CMPCS) |=> !avs_readdata[2])
        else $error("reserved control bit read as one");

    pin_zero_a: assert property (@(posedge clk) disable iff (rst)
        didis_q[0] |=> !pin_read[0] && pin_buffer_off[0])
        else $error("disabled pin not reading zero");

    reg_b_zero_a: assert property (@(posedge clk) disable iff (rst)
        adcsb_q[4:3] == 2'h0)
        else $error("register b bits 4:3 not zero");

endmodule : ccl_top

/* verif/tb_comparator_control_logic.sv */
// self-checking testbench for the comparator control logic
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
        errors++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
end

module tb_comparator_control_logic;
    import ccl_pkg::*;

    // ********************************************************
    // stimulus and observation signals
    // ********************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [CCL_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [CCL_DATA_W-1:0] avs_writedata = '0;
    logic [CCL_BE_W-1:0] avs_byteenable = 4'hf;
    logic [CCL_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [CCL_LVL_W-1:0] positive_pin = '0;
    logic [CCL_LVL_W-1:0] negative_pin = '0;
    logic [CCL_ADC_PINS*CCL_LVL_W-1:0] adc_pin = '0;
    logic [CCL_AIN_PINS-1:0] pin_digital_in = '0;
    logic [CCL_AIN_PINS-1:0] pin_read;
    logic [CCL_AIN_PINS-1:0] pin_buffer_off;
    logic global_irq_enable = 1'b0;
    logic irq_vector_ack = 1'b0;
    logic comparator_power_off;
    logic comparator_irq;
    int errors = 0;
    int tests_run = 0;
    logic [7:0] v;
    logic [1:0] modes [4] = '{CCL_MODE_TOGGLE, CCL_MODE_FALL, CCL_MODE_RISE,
        CCL_MODE_RSVD};
    logic ex_rise [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic ex_fall [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

    always #2.5 clk = ~clk;

    ccl_top ccl_top_inst (
        .clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .positive_pin(positive_pin), .negative_pin(negative_pin),
        .adc_pin(adc_pin), .pin_digital_in(pin_digital_in),
        .pin_read(pin_read), .pin_buffer_off(pin_buffer_off),
        .global_irq_enable(global_irq_enable),
        .irq_vector_ack(irq_vector_ack),
        .comparator_power_off(comparator_power_off),
        .comparator_irq(comparator_irq)
    );

    // ********************************************************
    // bus tasks: request held until waitrequest is sampled low
    // ********************************************************
    task automatic bus_wr(input logic [CCL_IDX_W-1:0] idx,
                          input logic [7:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [CCL_IDX_W-1:0] idx,
                          output logic [7:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
    endtask : bus_rd

    // lets the synchroniser, edge detector and flag settle
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask : settle

    task automatic set_cmp(input logic hi);
        positive_pin <= hi ? 8'h80 : 8'h10;
        negative_pin <= 8'h40;
        settle();
    endtask : set_cmp

    task automatic done(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, errors);
    endtask : done

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // ********************************************************
    // watchdog: the whole sequence needs a few hundred cycles
    // ********************************************************
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("[ERR] watchdog expected end seen timeout");
        end_sim();
    end

    // ********************************************************
    // test sequence
    // ********************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values, reserved bits and an unmapped index
        bus_rd(CCL_IDX_ADCSB, v); `CHK("adcsb rst", CCL_ADCSB_RST, v)
        bus_rd(CCL_IDX_CMPCS, v); `CHK("cmpcs rst", 8'h00, v)
        bus_rd(CCL_IDX_DIDIS, v); `CHK("didis rst", CCL_DIDIS_RST, v)
        bus_rd(6'h3f, v); `CHK("unmapped", 8'h00, v)
        bus_wr(CCL_IDX_ADCSB, 8'hff);
        bus_rd(CCL_IDX_ADCSB, v); `CHK("adcsb 4:3", 8'he7, v)
        // mux enable off again, or converter pin 0 replaces the negative pin
        bus_wr(CCL_IDX_ADCSB, 8'h00);
        bus_wr(CCL_IDX_CMPCS, 8'h04);
        bus_rd(CCL_IDX_CMPCS, v); `CHK("cmpcs bit2", 8'h00, v)
        avs_byteenable <= 4'h0;
        bus_wr(CCL_IDX_DIDIS, 8'h3f);
        avs_byteenable <= 4'hf;
        bus_rd(CCL_IDX_DIDIS, v); `CHK("be0 write", 8'h00, v)
        done("registers");
        // digital input disable of the comparator pins
        pin_digital_in <= 2'b11;
        bus_wr(CCL_IDX_DIDIS, 8'hff);
        bus_rd(CCL_IDX_DIDIS, v); `CHK("didis rw", 8'h3f, v)
        repeat (2) @(posedge clk);
        `CHK("pin_read off", 2'b00, pin_read)
        `CHK("buffer off", 2'b11, pin_buffer_off)
        bus_wr(CCL_IDX_DIDIS, 8'h01);
        repeat (2) @(posedge clk);
        `CHK("pin_read one", 2'b10, pin_read)
        `CHK("buffer one", 2'b01, pin_buffer_off)
        done("input disable");
        // comparison, strict, through the synchroniser
        positive_pin <= 8'h41;
        negative_pin <= 8'h40;
        settle();
        bus_rd(CCL_IDX_CMPCS, v); `CHK("above", 1'b1, v[5])
        positive_pin <= 8'h40;
        settle();
        bus_rd(CCL_IDX_CMPCS, v); `CHK("equal", 1'b0, v[5])
        // bandgap replaces the positive pin
        positive_pin <= 8'hff;
        negative_pin <= 8'h37;
        bus_wr(CCL_IDX_CMPCS, 8'h40);
        settle();
        bus_rd(CCL_IDX_CMPCS, v); `CHK("bg above", 1'b1, v[5])
        negative_pin <= 8'h38;
        settle();
        bus_rd(CCL_IDX_CMPCS, v); `CHK("bg equal", 1'b0, v[5])
        bus_wr(CCL_IDX_CMPCS, 8'h10);
        settle();
        bus_rd(CCL_IDX_CMPCS, v); `CHK("bg off", 1'b1, v[5])
        done("comparison");
        // negative input multiplexer
        positive_pin <= 8'h80;
        negative_pin <= 8'hf0;
        adc_pin <= 32'hf010_f010;
        bus_wr(CCL_IDX_ADCSB, 8'h40);
        for (int ch = 0; ch < 4; ch++) begin
            bus_wr(CCL_IDX_CONV, 8'(ch));
            settle();
            bus_rd(CCL_IDX_CMPCS, v); `CHK("mux ch", ~ch[0], v[5])
        end
        bus_wr(CCL_IDX_CONV, 8'h80);
        settle();
        bus_rd(CCL_IDX_CMPCS, v); `CHK("conv on", 1'b0, v[5])
        bus_wr(CCL_IDX_CONV, 8'h00);
        bus_wr(CCL_IDX_ADCSB, 8'h00);
        settle();
        bus_rd(CCL_IDX_CMPCS, v); `CHK("mux off", 1'b0, v[5])
        done("multiplexer");
        // event modes, reserved code last; enable stays low meanwhile
        for (int i = 0; i < 4; i++) begin
            set_cmp(1'b0);
            bus_wr(CCL_IDX_CMPCS, {6'h04, modes[i]});
            set_cmp(1'b1);
            bus_rd(CCL_IDX_CMPCS, v); `CHK("rise ev", ex_rise[i], v[4])
            bus_wr(CCL_IDX_CMPCS, {6'h04, modes[i]});
            set_cmp(1'b0);
            bus_rd(CCL_IDX_CMPCS, v); `CHK("fall ev", ex_fall[i], v[4])
        end
        done("event modes");
        // flag, enable and global enable
        bus_wr(CCL_IDX_CMPCS, 8'h10);
        set_cmp(1'b1);
        global_irq_enable <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, comparator_irq)
        bus_wr(CCL_IDX_CMPCS, 8'h08);
        bus_rd(CCL_IDX_CMPCS, v); `CHK("zero keeps", 1'b1, v[4])
        `CHK("irq on", 1'b1, comparator_irq)
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("irq global", 1'b0, comparator_irq)
        global_irq_enable <= 1'b1;
        irq_vector_ack <= 1'b1;
        @(posedge clk);
        irq_vector_ack <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("irq ack", 1'b0, comparator_irq)
        bus_rd(CCL_IDX_CMPCS, v); `CHK("ack clears", 1'b0, v[4])
        done("interrupt flag");
        // sticky status, enable and clear registers
        bus_wr(CCL_IDX_CMPCS, 8'h00);
        bus_rd(CCL_IDX_ISTAT, v); `CHK("status", 8'h03, v)
        bus_wr(CCL_IDX_IEN, 8'h01);
        repeat (2) @(posedge clk);
        `CHK("status irq", 1'b1, comparator_irq)
        bus_wr(CCL_IDX_IEN, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("status mask", 1'b0, comparator_irq)
        bus_wr(CCL_IDX_ICLR, 8'h03);
        bus_rd(CCL_IDX_ISTAT, v); `CHK("status clr", 8'h00, v)
        bus_rd(CCL_IDX_ICLR, v); `CHK("clear reads", 8'h00, v)
        done("status registers");
        // power-down with the enable already low
        bus_wr(CCL_IDX_CMPCS, 8'h80);
        settle();
        `CHK("power off", 1'b1, comparator_power_off)
        bus_rd(CCL_IDX_CMPCS, v); `CHK("off result", 1'b0, v[5])
        bus_wr(CCL_IDX_CMPCS, 8'h10);
        settle();
        `CHK("power on", 1'b0, comparator_power_off)
        done("power");
        end_sim();
    end

endmodule : tb_comparator_control_logic
